// File: rtl/sbr_pkg.sv
package sbr_pkg;
    // ---------------------------------------------------------------
    // register map (byte offsets on a 32-bit bus)
    // ---------------------------------------------------------------
    localparam logic [3:0] ADDR_BAUD_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_DIVISOR_LOW = 4'h4;
    localparam logic [3:0] ADDR_DIVISOR_HIGH = 4'h8;
    localparam logic [3:0] ADDR_MODE = 4'hC;
    // ---------------------------------------------------------------
    // baud_control fields
    // ---------------------------------------------------------------
    localparam int BIT_ABD_OVF = 7;
    localparam int BIT_RX_IDLE = 6;
    localparam int BIT_POLARITY = 4;
    localparam int BIT_WIDE = 3;
    localparam int BIT_WAKE = 1;
    localparam int BIT_AUTO = 0;
    // mode register fields
    localparam int BIT_SYNC = 1;
    localparam int BIT_HIGH_SPEED = 0;
    // ---------------------------------------------------------------
    // reset values and prescaler limits (multiplier minus one)
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIVISOR = 16'h0000;
    localparam logic [5:0] PRE_MUL_64 = 6'h3F;
    localparam logic [5:0] PRE_MUL_16 = 6'h0F;
    localparam logic [5:0] PRE_MUL_4 = 6'h03;
    typedef enum logic [1:0] {AB_IDLE, AB_WAIT, AB_MEAS} sbr_ab_state_t;
endpackage : sbr_pkg

// File: rtl/sbr_tick_if.sv
`timescale 1ns/1ps
interface sbr_tick_if;
    logic [15:0] divisor;
    logic [5:0] pre_max;
    logic clear;
    logic pre_tick;
    logic bit_tick;
    modport timer (input divisor, input pre_max, input clear, output pre_tick, output bit_tick);
    modport ctrl (output divisor, output pre_max, output clear, input pre_tick, input bit_tick);
endinterface : sbr_tick_if

// File: rtl/sbr_timer.sv
`timescale 1ns/1ps
module sbr_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    sbr_tick_if.timer tif
);
    logic [5:0] pre_q;
    logic [15:0] cnt_q;
    logic bit_tick_q;
    wire pre_wrap = (pre_q == tif.pre_max);
    wire bit_wrap = pre_wrap && (cnt_q == tif.divisor);

    // free-running: period is (pre_max+1)*(divisor+1) clocks
    always_ff @(posedge clk_i) begin
        if (rst_i || tif.clear) begin
            pre_q <= 6'h00;
            cnt_q <= sbr_pkg::RST_DIVISOR;
            bit_tick_q <= 1'b0;
        end else begin
            pre_q <= pre_wrap ? 6'h00 : pre_q + 6'h01;
            if (pre_wrap) begin
                cnt_q <= bit_wrap ? sbr_pkg::RST_DIVISOR : cnt_q + 16'h0001;
            end
            bit_tick_q <= bit_wrap;
        end
    end

    assign tif.pre_tick = pre_wrap;
    assign tif.bit_tick = bit_tick_q;

    a_clear_restarts: assert property (@(posedge clk_i) disable iff (rst_i)
        tif.clear |=> (pre_q == 6'h00) && (cnt_q == 16'h0000)) else $error("clear missed");
    a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        tif.bit_tick && !tif.clear |=> !tif.bit_tick) else $error("ticks too close");
endmodule : sbr_timer

// File: rtl/sbr_top.sv
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - async polarity bit inverts transmit data
// - eight-bit divisor by default, sixteen when wide
// - divisor pair sets free-running timer period
// - async multiplier from high-speed and width
// - sync mode ignores high-speed select
// - rates: 64, 16 or 4 times divisor+1
// - any divisor write clears the timer
module sbr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic tx_data_i,
    input wire logic rx_pin_i,
    input wire logic receiver_idle_flag_i,
    input wire logic rx_flag_clr_i,
    output logic tx_pin_o,
    output logic baud_tick_o,
    output logic rx_accept_o,
    output logic receive_interrupt_flag_o
);
    sbr_tick_if tif();
    sbr_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tif(tif)
    );

    logic ack_q;
    logic [31:0] dat_q;
    logic pol_q, wide_q, wake_q, abd_q, ovf_q, sync_q, hs_q, flag_q;
    logic [7:0] div_lo_q, div_hi_q;
    logic [15:0] meas_q;
    logic rx_s1_q, rx_s2_q, rx_s3_q, tx_q;
    sbr_pkg::sbr_ab_state_t ab_q;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire req = cyc_i && stb_i && !ack_q;
    wire wr = req && we_i && sel_i[0];
    wire hit_ctrl = (adr_i == sbr_pkg::ADDR_BAUD_CONTROL);
    wire hit_lo = (adr_i == sbr_pkg::ADDR_DIVISOR_LOW);
    wire hit_hi = (adr_i == sbr_pkg::ADDR_DIVISOR_HIGH);
    wire hit_mode = (adr_i == sbr_pkg::ADDR_MODE);
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_mode = wr && hit_mode;
    wire [7:0] wb = dat_i[7:0];
    wire [7:0] ctrl_rd = {ovf_q, receiver_idle_flag_i, 1'b0, pol_q, wide_q, 1'b0, wake_q, abd_q};
    wire [7:0] mode_rd = {6'h00, sync_q, hs_q};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_lo ? div_lo_q :
                         hit_hi ? div_hi_q :
                         hit_mode ? mode_rd : 8'h00;

    // ---------------------------------------------------------------
    // receive line watch and auto-rate measurement
    // ---------------------------------------------------------------
    wire rx_fall = rx_s3_q && !rx_s2_q;
    wire rx_rise = !rx_s3_q && rx_s2_q;
    wire async_m = !sync_q;
    wire wake_hit = wake_q && async_m && rx_fall;
    wire ab_start = wr_ctrl && wb[sbr_pkg::BIT_AUTO] && async_m;
    wire [15:0] meas_lim = wide_q ? 16'hFFFF : 16'h00FF;
    wire ab_ovf = (ab_q == sbr_pkg::AB_MEAS) && tif.pre_tick && (meas_q == meas_lim);
    wire ab_done = (ab_q == sbr_pkg::AB_MEAS) && rx_rise && !ab_ovf;
    wire [15:0] meas_div = (meas_q == 16'h0000) ? 16'h0000 : meas_q - 16'h0001;
    wire div_wr = (wr && (hit_lo || hit_hi)) || ab_done;

    // ---------------------------------------------------------------
    // timer steering
    // ---------------------------------------------------------------
    // sync ignores high-speed; async picks by width and high-speed
    wire [5:0] async_max = wide_q ? (hs_q ? sbr_pkg::PRE_MUL_4 : sbr_pkg::PRE_MUL_16)
                                  : (hs_q ? sbr_pkg::PRE_MUL_16 : sbr_pkg::PRE_MUL_64);
    assign tif.pre_max = sync_q ? sbr_pkg::PRE_MUL_4 : async_max;
    assign tif.divisor = wide_q ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
    // measurement restarts the prescaler so counts align with the start edge
    assign tif.clear = div_wr || ((ab_q == sbr_pkg::AB_WAIT) && rx_fall);

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            dat_q <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pol_q <= 1'b0;
            wide_q <= 1'b0;
            sync_q <= 1'b0;
            hs_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                pol_q <= wb[sbr_pkg::BIT_POLARITY];
                wide_q <= wb[sbr_pkg::BIT_WIDE];
            end
            if (wr_mode) begin
                sync_q <= wb[sbr_pkg::BIT_SYNC];
                hs_q <= wb[sbr_pkg::BIT_HIGH_SPEED];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_lo_q <= sbr_pkg::RST_BYTE;
            div_hi_q <= sbr_pkg::RST_BYTE;
        end else if (ab_done) begin
            div_lo_q <= meas_div[7:0];
            div_hi_q <= wide_q ? meas_div[15:8] : div_hi_q;
        end else if (wr && hit_lo) begin
            div_lo_q <= wb;
        end else if (wr && hit_hi) begin
            div_hi_q <= wb;
        end
    end

    // hardware clear of wake loses to nothing; software write applies unless flag and wake are both set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            if (flag_q && wake_q) begin
                wake_q <= 1'b0;
            end else if (wr_ctrl) begin
                wake_q <= wb[sbr_pkg::BIT_WAKE];
            end
            // set wins over clear
            flag_q <= wake_hit || (flag_q && !rx_flag_clr_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abd_q <= 1'b0;
            ovf_q <= 1'b0;
            meas_q <= 16'h0000;
            ab_q <= sbr_pkg::AB_IDLE;
        end else begin
            case (ab_q)
                sbr_pkg::AB_IDLE: begin
                    if (ab_start) begin
                        abd_q <= 1'b1;
                        ovf_q <= 1'b0;
                        ab_q <= sbr_pkg::AB_WAIT;
                    end else if (wr_ctrl) begin
                        ovf_q <= ovf_q && wb[sbr_pkg::BIT_ABD_OVF];
                    end
                end
                sbr_pkg::AB_WAIT: begin
                    meas_q <= 16'h0000;
                    if (rx_fall) begin
                        ab_q <= sbr_pkg::AB_MEAS;
                    end
                end
                sbr_pkg::AB_MEAS: begin
                    // the start bit of a 0x55 sync byte spans one bit period
                    if (ab_ovf) begin
                        ovf_q <= 1'b1;
                        abd_q <= 1'b0;
                        ab_q <= sbr_pkg::AB_IDLE;
                    end else if (ab_done) begin
                        abd_q <= 1'b0;
                        ab_q <= sbr_pkg::AB_IDLE;
                    end else if (tif.pre_tick) begin
                        meas_q <= meas_q + 16'h0001;
                    end
                end
                default: ab_q <= sbr_pkg::AB_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            tx_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_pin_i;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            tx_q <= (async_m && pol_q) ? !tx_data_i : tx_data_i;
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign tx_pin_o = tx_q;
    assign baud_tick_o = tif.bit_tick;
    assign rx_accept_o = !(wake_q && async_m);
    assign receive_interrupt_flag_o = flag_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_tx_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
        !sync_q && !$past(sync_q) && pol_q && $past(pol_q) |-> tx_pin_o == !$past(tx_data_i))
        else $error("tx polarity wrong");
    a_narrow_divisor: assert property (@(posedge clk_i) disable iff (rst_i)
        !wide_q |-> tif.divisor[15:8] == 8'h00) else $error("high byte leaks");
    a_wake_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_hit |=> flag_q ##1 !wake_q) else $error("wake not cleared");
    a_async_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        !sync_q && !wide_q && !hs_q |-> tif.pre_max == 6'h3F) else $error("bad x64");
    a_sync_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        sync_q |-> tif.pre_max == 6'h03) else $error("sync uses high speed");
    a_wide_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        !sync_q && wide_q && !hs_q |-> tif.pre_max == 6'h0F) else $error("bad x16");
    a_div_write_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_lo |-> tif.clear ##1 div_lo_q == $past(wb)) else $error("no clear");
    a_auto_done: assert property (@(posedge clk_i) disable iff (rst_i)
        ab_done |=> !abd_q && ab_q == sbr_pkg::AB_IDLE) else $error("auto stuck");
    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && hit_ctrl |-> dat_o[5] == 1'b0 && dat_o[2] == 1'b0) else $error("bit 5/2 set");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held");
endmodule : sbr_top

// File: tb/sbr_peer.sv
`timescale 1ns/1ps
// -----------------------------------------------
// remote serial peer: drives the receive line
// -----------------------------------------------
module sbr_peer (
    input wire logic clk_i,
    output logic rx_o
);
    // line rests high between frames, like a stop bit
    initial rx_o = 1'b1;
    // one low pulse: a wake start edge or an auto-rate sync field
    task automatic send_low(input int cycles);
        @(posedge clk_i);
        rx_o <= 1'b0;
        repeat (cycles) @(posedge clk_i);
        rx_o <= 1'b1;
    endtask : send_low
endmodule : sbr_peer

// File: tb/sbr_top_bench.sv
`timescale 1ns/1ps
module sbr_top_bench;
    // -----------------------------------------------
    // signals and instances
    // -----------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic tx_data_i = 1'b0;
    logic idle_i = 1'b1;
    logic clr_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, rx_pin, tx_pin_o, tick_o, accept_o, flag_o;
    logic [7:0] rd;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 32'h14aea373;
    sbr_top i_sbr_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .tx_data_i(tx_data_i), .rx_pin_i(rx_pin), .receiver_idle_flag_i(idle_i),
        .rx_flag_clr_i(clr_i), .tx_pin_o(tx_pin_o), .baud_tick_o(tick_o),
        .rx_accept_o(accept_o), .receive_interrupt_flag_o(flag_o));
    sbr_peer u_peer (.clk_i(clk_i), .rx_o(rx_pin));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) tx_data_i <= 1'($random(seed));
    // -----------------------------------------------
    // shared tasks
    // -----------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    // request held until the rising edge that sees ack; data taken and request dropped there
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    // model of the pin: every other data bit queued, shown one clock later
    task automatic tx_check(input logic inv);
        logic exp_q[$];
        repeat (16) begin
            @(negedge clk_i);
            exp_q.push_back(tx_data_i ^ inv);
            @(negedge clk_i);
            check("tx_pin", exp_q.pop_front(), tx_pin_o);
        end
    endtask : tx_check
    task automatic rate(input logic s, input logic h, input logic w);
        int m, n, cnt;
        logic [7:0] lo;
        lo = 8'($random(seed)) & 8'h07;
        m = s ? 4 : (w ? 16 : 64) / (h ? 4 : 1);
        n = w ? 256 + lo : lo;
        wb(1'b1, sbr_pkg::ADDR_MODE, {6'h00, s, h});
        wb(1'b1, sbr_pkg::ADDR_BAUD_CONTROL, {4'h0, w, 3'h0});
        wb(1'b1, sbr_pkg::ADDR_DIVISOR_HIGH, 8'h01);
        wb(1'b1, sbr_pkg::ADDR_DIVISOR_LOW, lo);
        cnt = 0;
        do begin @(negedge clk_i); cnt++; end while (tick_o !== 1'b1);
        check("first_tick", m * (n + 1), cnt);
        cnt = 0;
        do begin @(negedge clk_i); cnt++; end while (tick_o !== 1'b1);
        check("tick_period", m * (n + 1), cnt);
        $display("test rate sync=%0b hs=%0b wide=%0b done", s, h, w);
    endtask : rate
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial begin
        int k;
        logic [3:0] adrs [4] = '{4'h4, 4'h8, 4'hC, 4'h1};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            idle_i <= 1'(i);
            wb(1'b0, sbr_pkg::ADDR_BAUD_CONTROL, 8'h00);
            check("control_reset", {1'b0, 1'(i), 6'h00}, rd);
        end
        foreach (adrs[j]) begin
            wb(1'b0, adrs[j], 8'h00);
            check("reg_reset", 0, rd);
        end
        wb(1'b1, sbr_pkg::ADDR_BAUD_CONTROL, 8'h7C);
        wb(1'b0, sbr_pkg::ADDR_BAUD_CONTROL, 8'h00);
        check("control_bits", 8'h58, rd);
        $display("test reset done");
        tx_check(1'b1);
        wb(1'b1, sbr_pkg::ADDR_MODE, 8'h02);
        tx_check(1'b0);
        $display("test polarity done");
        rate(1'b0, 1'b0, 1'b0);
        rate(1'b0, 1'b1, 1'b0);
        rate(1'b0, 1'b0, 1'b1);
        rate(1'b0, 1'b1, 1'b1);
        rate(1'b1, 1'b0, 1'b0);
        rate(1'b1, 1'b1, 1'b1);
        wb(1'b1, sbr_pkg::ADDR_MODE, 8'h00);
        wb(1'b1, sbr_pkg::ADDR_BAUD_CONTROL, 8'h02);
        check("accept_armed", 0, accept_o);
        u_peer.send_low(20);
        wb(1'b0, sbr_pkg::ADDR_BAUD_CONTROL, 8'h00);
        check("wake_cleared", 8'h40, rd);
        check("wake_flag", 1, flag_o);
        check("accept_back", 1, accept_o);
        clr_i <= 1'b1;
        @(posedge clk_i);
        clr_i <= 1'b0;
        @(negedge clk_i);
        @(negedge clk_i);
        check("flag_clear", 0, flag_o);
        $display("test wake done");
        // measured span is padded by half a prescaler wrap against edge alignment
        k = 3 + ($random(seed) & 7);
        wb(1'b1, sbr_pkg::ADDR_BAUD_CONTROL, 8'h01);
        u_peer.send_low(64 * k + 32);
        repeat (8) @(posedge clk_i);
        wb(1'b0, sbr_pkg::ADDR_DIVISOR_LOW, 8'h00);
        check("auto_divisor", k - 1, rd);
        wb(1'b0, sbr_pkg::ADDR_BAUD_CONTROL, 8'h00);
        check("auto_cleared", 8'h40, rd);
        // a low span longer than 256 wraps of the x16 prescaler overflows the narrow count
        wb(1'b1, sbr_pkg::ADDR_MODE, 8'h01);
        wb(1'b1, sbr_pkg::ADDR_BAUD_CONTROL, 8'h01);
        u_peer.send_low(16 * 256 + 64);
        wb(1'b0, sbr_pkg::ADDR_BAUD_CONTROL, 8'h00);
        check("auto_overflow", 8'hC0, rd);
        wb(1'b1, sbr_pkg::ADDR_BAUD_CONTROL, 8'h00);
        wb(1'b0, sbr_pkg::ADDR_BAUD_CONTROL, 8'h00);
        check("overflow_cleared", 8'h40, rd);
        $display("test auto rate done");
        tally_and_finish;
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        tally_and_finish;
    end
endmodule : sbr_top_bench
